// ==== tb_urscf_bank.sv ====
// Self-checking bench for the bank: reset values, reset kinds, locks, CTS gating.
// Assumes the checker is bound in and the modem peer drives the modem pins.
`timescale 1ns/100ps
module tb_urscf_bank;
  logic        CLOCK = 1'b0;
  logic        POR_N = 1'b0;
  logic        RST_N = 1'b0;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic [4:0]  ADDR = 5'h00;
  logic [7:0]  WDATA = 8'h00;
  logic [7:0]  RDATA;
  logic        TX, RTS_N, DTR_N, IRQ_N;
  wire         CTS_N, DSR_N, RI_N, CD_N;
  logic [3:0]  want = 4'hf;       // Modem levels asked of the peer.
  int          fails = 0;
  int          checked = 0;
  int          cycles = 0;
  logic [15:0] seed = 16'd38492;  // Fixed start of the random sequence.
  logic [7:0]  wrote [0:31];      // Last random value written per index.
  // Index and reset value of every readable register but modem status, as {index, value}.
  localparam logic [12:0] RTAB [0:22] = '{13'h0100, 13'h0201, 13'h041d, 13'h0500, 13'h0660,
    13'h08ff, 13'h090f, 13'h0a00, 13'h0b40, 13'h0c00, 13'h0d00, 13'h0e00, 13'h0f00, 13'h1000, 13'h1100,
    13'h1200, 13'h1301, 13'h1400, 13'h1500, 13'h1600, 13'h1700, 13'h1800, 13'h1900};

  urscf_bank u_dut (.CLOCK(CLOCK), .POR_N(POR_N), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .CTS_N(CTS_N), .DSR_N(DSR_N), .RI_N(RI_N), .CD_N(CD_N),
    .TX(TX), .RTS_N(RTS_N), .DTR_N(DTR_N), .IRQ_N(IRQ_N));
  urscf_modem_peer u_peer (.want(want), .lag(4'h2), .clk(CLOCK), .pins({CD_N, RI_N, DSR_N, CTS_N}));

  initial forever #12.5 CLOCK = ~CLOCK;
  // Cut a hang short well beyond the expected run length.
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fails++;
      tally_and_finish();
    end
  end

  // Next value of the feedback shift register, low byte returned.
  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction
  // Value expected after a reset: power-up-only registers keep their data.
  function automatic logic [7:0] expect_after(input logic [12:0] t);
    if (t[12:8] inside {5'h08, 5'h13, 5'h14, [5'h16:5'h19]})
      return wrote[t[12:8]];
    return t[7:0];
  endfunction
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLOCK);
    WR <= 1'b0;
    @(posedge CLOCK);
  endtask
  // Read strobe for one cycle; data are looked at in the following cycle.
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input string what);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLOCK);
    RD <= 1'b0;
    @(negedge CLOCK) chk(what, RDATA, e);
    @(posedge CLOCK);
  endtask
  // Write immediately followed by a read of the same index.
  task automatic wr_rd(input logic [4:0] a, input logic [7:0] d);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLOCK);
    WR <= 1'b0;
    rd(a, d, "readback");
  endtask
  // Pin reset pulse; the serial and modem outputs must sit high within it.
  task automatic pin_reset();
    RST_N <= 1'b0;
    repeat (2) @(posedge CLOCK);
    @(negedge CLOCK) chk("idle outputs", {4'h0, TX, RTS_N, DTR_N, IRQ_N}, 8'h0f);
    @(posedge CLOCK);
    RST_N <= 1'b1;
    @(posedge CLOCK);
  endtask
  // Sample one 8N1 frame at mid-bit, 16 clocks per bit for divisor one.
  task automatic rx_frame(input logic [7:0] e);
    logic [7:0] got;
    int n;
    n = 0;
    while (TX !== 1'b0 && n < 600) begin
      @(negedge CLOCK);
      n++;
    end
    chk("frame start", {7'h00, n < 600}, 8'h01);
    repeat (8) @(negedge CLOCK);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(negedge CLOCK);
      got[i] = TX;
    end
    repeat (16) @(negedge CLOCK);
    chk("stop bit", {7'h00, TX}, 8'h01);
    chk("frame byte", got, e);
    @(posedge CLOCK);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence: each block below is one test.
  initial begin
    int n;
    logic [7:0] a, b;
    logic [4:0] r;
    repeat (4) @(posedge CLOCK);
    POR_N <= 1'b1;
    RST_N <= 1'b1;
    @(posedge CLOCK);
    foreach (RTAB[i]) rd(RTAB[i][12:8], RTAB[i][7:0], "power-up value");
    $display("test power-up values done");
    for (int k = 0; k < 2; k++) begin
      wr(5'h12, 8'h10);
      foreach (RTAB[i]) begin
        r = RTAB[i][12:8];
        if (!(r inside {5'h02, 5'h06, 5'h0b, 5'h0c, 5'h10, 5'h12})) begin
          wrote[r] = rnd();
          wr_rd(r, wrote[r]);
        end
      end
      if (k == 0)
        pin_reset();
      else
        wr(5'h10, 8'h08);
      foreach (RTAB[i]) rd(RTAB[i][12:8], expect_after(RTAB[i]), "after reset");
    end
    $display("test reset kinds done");
    wr(5'h05, 8'h03);
    wr(5'h01, 8'h08);
    want <= 4'b1010;
    repeat (12) @(negedge CLOCK);
    chk("modem irq", {7'h00, IRQ_N}, 8'h00);
    @(posedge CLOCK);
    pin_reset();
    repeat (10) @(posedge CLOCK);
    rd(5'h07, 8'h50, "modem status");
    $display("test modem status done");
    wr(5'h15, 8'h25);
    rd(5'h15, 8'h00, "locked fraction");
    wr(5'h01, 8'hff);
    rd(5'h01, 8'h0f, "locked enables");
    rd(5'h1f, 8'h00, "unmapped");
    $display("test locked bits done");
    wr(5'h13, 8'h01);
    wr(5'h14, 8'h00);
    wr(5'h12, 8'h80);
    a = rnd();
    b = rnd();
    wr(5'h1a, a);
    fork
      rx_frame(a);
      begin
        repeat (70) @(posedge CLOCK);
        want[0] <= 1'b1;
      end
    join
    wr(5'h1a, b);
    n = 0;
    repeat (400) begin
      @(negedge CLOCK);
      n += (TX === 1'b0);
    end
    chk("paused line", {7'h00, n != 0}, 8'h00);
    @(posedge CLOCK);
    want[0] <= 1'b0;
    rx_frame(b);
    $display("test transmit gating done");
    tally_and_finish();
  end
endmodule

// ==== urscf_bank.v ====
// Register bank of one UART channel with reset-state handling, automatic
// clear-to-send transmit gating and the four flow-control character registers.
// Assumes one clock, synchronous active-low resets, a plain register port
// with one-cycle strobes, and modem pins asynchronous to CLOCK.
`timescale 1ns/100ps
`include "urscf_consts.vh"

module urscf_bank (
  // Clock and the two synchronous resets.
  input  wire       CLOCK,
  input  wire       POR_N,
  input  wire       RST_N,
  // Register port.
  input  wire [4:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  // Modem inputs, asynchronous to CLOCK.
  input  wire       CTS_N,
  input  wire       DSR_N,
  input  wire       RI_N,
  input  wire       CD_N,
  // Serial and modem outputs, all from flops.
  output reg        TX,
  output reg        RTS_N,
  output reg        DTR_N,
  output reg        IRQ_N
);

  // Power-up-only registers. Pin and software resets leave
  // them alone, so a running link keeps its divisor and its
  // flow characters.
  reg [7:0] divisor_low_byte;   // Baud divisor, low byte.
  reg [7:0] divisor_high_byte;  // Baud divisor, high byte.
  reg [7:0] scratch_pad;        // Free software storage.
  reg [7:0] resume_char_one;    // First transmit-on character.
  reg [7:0] resume_char_two;    // Second transmit-on character.
  reg [7:0] halt_char_one;      // First transmit-off character.
  reg [7:0] halt_char_two;      // Second transmit-off character.

  // Registers cleared by every reset.
  // Their reset values leave the enhanced bits locked.
  reg [7:0] divisor_fraction;        // Fraction and oversampling select.
  reg [7:0] interrupt_enable;        // Interrupt enables.
  reg [7:0] fifo_control;            // FIFO control, write only.
  reg [7:0] line_control;            // Line format control.
  reg [7:0] modem_control;           // Modem output control.
  reg [7:0] flow_halt_resume_levels; // Halt and resume levels.
  reg [7:0] fifo_trigger_levels;     // FIFO trigger levels.
  reg [7:0] gpio_direction;          // GPIO direction.
  reg [7:0] gpio_level;              // GPIO output level.
  reg [7:0] gpio_irq_enable;         // GPIO interrupt enables.
  reg [7:0] io_control;              // I/O control.
  reg [7:0] extra_feature_control;   // Extra feature control.
  reg [7:0] enhanced_feature;        // Enhanced feature control.
  reg [3:0] modem_change;            // Sticky modem input change flags.
  reg [3:0] modem_prev;              // Last synchronised modem levels.
  reg       hold_full;               // Transmit holding stage occupied.
  reg [7:0] transmit_holding;        // Byte waiting for the shifter.

  // Resets, strobes and internal views.
  wire       any_rst;     // Pin, software or power-up reset.
  wire       soft_rst;    // Software reset request this cycle.
  wire       wr_en;       // Register write accepted.
  wire       enh_on;      // Enhanced bits may be modified.
  wire [3:0] modem_lvl;   // Synchronised pins: CTS, DSR, RI, CD.
  wire       cts_pause;   // Transmitter must not start a frame.
  wire       tx_take;     // Shifter took the holding byte.
  wire       tx_busy;     // Shifter is sending.
  wire       tx_line;     // Serial line from the shifter.
  wire [7:0] modem_state; // Modem status value.
  wire [7:0] line_state;  // Line status value.
  wire       modem_irq;   // Enabled modem change pending.

  reg  [7:0] next_rdata;  // Read data selected this cycle.

  // A write of one to the software reset bit resets the bank next edge.
  // The strobe is decoded from the port, so the reset lands at the very
  // edge of the write, and the rest of that write is dropped: nothing it
  // carried can outlive the reset it caused.
  assign soft_rst = WR && (ADDR == `URSCF_A_IOCTL) && WDATA[`URSCF_IO_SRST];
  assign any_rst  = !RST_N || !POR_N || soft_rst;
  assign wr_en    = WR && !soft_rst;
  assign enh_on   = enhanced_feature[`URSCF_EF_ENH];

  // Pin synchroniser for the four modem inputs.
  // Only power-up resets it, so a pin or software reset never
  // makes the modem levels look freshly changed.
  urscf_sync u_sync (
    .clk   (CLOCK),
    .rst   (!POR_N),
    .pin   ({CD_N, RI_N, DSR_N, CTS_N}),
    .level (modem_lvl)
  );

  // Auto clear-to-send: a high CTS stops new frames, a low one lets them go.
  // The transmitter disable bit holds frames back the same way.
  // CTS acts a few clocks late through the synchroniser; a frame
  // started in that gap still runs to its stop bit.
  assign cts_pause = (enhanced_feature[`URSCF_EF_ACTS] && modem_lvl[0])
                   || extra_feature_control[`URSCF_XF_TXDIS];

  // Serial shifter; frames already started complete unless a reset cuts them.
  // It takes the holding byte only between frames.
  urscf_tx u_tx (
    .clk       (CLOCK),
    .rst       (any_rst),
    .divisor   ({divisor_high_byte, divisor_low_byte}),
    .samp_sel  (divisor_fraction[5:4]),
    .hold_full (hold_full),
    .hold_data (transmit_holding),
    .pause     (cts_pause),
    .take      (tx_take),
    .busy      (tx_busy),
    .txd       (tx_line)
  );

  // Status views; upper modem bits are pin levels inverted.
  // Line status bit 6: holding stage and shifter both empty.
  // Line status bit 5: holding stage empty. There is no
  // receiver, so the receive bits stay clear.
  assign modem_state = {~modem_lvl, modem_change};
  assign line_state  = {1'b0, !hold_full && !tx_busy, !hold_full, 5'h00};
  assign modem_irq   = interrupt_enable[`URSCF_IE_MODEM] && (modem_change != 4'h0);

  // Merge a write, keeping enhanced bits locked unless enhanced enable is set.
  // Unmasked bits are written as usual, so legacy software
  // still reaches them while the enhanced bits stay latched.
  function [7:0] enh_merge;
    input [7:0] old_v;
    input [7:0] new_v;
    input [7:0] mask;
    input       allow;
    begin
      enh_merge = allow ? new_v : ((old_v & mask) | (new_v & ~mask));
    end
  endfunction

  // Power-up-only registers: only POR_N resets them.
  // Writes reach them even in a pin or software reset, since
  // neither reset clears them.
  always @(posedge CLOCK) begin
    if (!POR_N) begin
      divisor_low_byte  <= `URSCF_RST_DIVLO;
      divisor_high_byte <= `URSCF_RST_DIVHI;
      scratch_pad       <= `URSCF_RST_SCR;
      resume_char_one   <= `URSCF_RST_CHAR;
      resume_char_two   <= `URSCF_RST_CHAR;
      halt_char_one     <= `URSCF_RST_CHAR;
      halt_char_two     <= `URSCF_RST_CHAR;
    end else if (WR) begin
      // Character registers are plain read-write storage.
      case (ADDR)
        // The shifter picks up a new divisor at its next bit.
        `URSCF_A_DIVLO:   divisor_low_byte  <= WDATA;
        `URSCF_A_DIVHI:   divisor_high_byte <= WDATA;
        `URSCF_A_SCRATCH: scratch_pad       <= WDATA;
        `URSCF_A_RES1:    resume_char_one   <= WDATA;
        `URSCF_A_RES2:    resume_char_two   <= WDATA;
        `URSCF_A_HALT1:   halt_char_one     <= WDATA;
        `URSCF_A_HALT2:   halt_char_two     <= WDATA;
        // Other indexes leave these registers alone.
        default: begin
          divisor_low_byte <= divisor_low_byte;
        end
      endcase
    end
  end

  // Control registers: every reset clears them to their reset values.
  // Registers with enhanced bits pass through the lock; the
  // fraction, halt-resume and trigger registers lock whole.
  always @(posedge CLOCK) begin
    if (any_rst) begin
      // Line control and halt-resume levels reset non-zero.
      divisor_fraction        <= `URSCF_RST_ZERO;
      interrupt_enable        <= `URSCF_RST_ZERO;
      fifo_control            <= `URSCF_RST_ZERO;
      line_control            <= `URSCF_RST_LCTL;
      modem_control           <= `URSCF_RST_ZERO;
      flow_halt_resume_levels <= `URSCF_RST_TCR;
      fifo_trigger_levels     <= `URSCF_RST_ZERO;
      gpio_direction          <= `URSCF_RST_ZERO;
      gpio_level              <= `URSCF_RST_ZERO;
      gpio_irq_enable         <= `URSCF_RST_ZERO;
      io_control              <= `URSCF_RST_ZERO;
      extra_feature_control   <= `URSCF_RST_ZERO;
      enhanced_feature        <= `URSCF_RST_ZERO;
    end else if (wr_en) begin
      case (ADDR)
        `URSCF_A_DIVFR: begin
          if (enh_on) begin
            divisor_fraction <= WDATA;
          end
        end
        `URSCF_A_IENA: begin
          interrupt_enable <= enh_merge(interrupt_enable, WDATA, `URSCF_MASK_IENA, enh_on);
        end
        `URSCF_A_FCTL: begin
          fifo_control <= enh_merge(fifo_control, WDATA, `URSCF_MASK_FCTL, enh_on);
        end
        `URSCF_A_MCTL: begin
          modem_control <= enh_merge(modem_control, WDATA, `URSCF_MASK_MCTL, enh_on);
        end
        `URSCF_A_TCR: begin
          if (enh_on) begin
            flow_halt_resume_levels <= WDATA;
          end
        end
        `URSCF_A_TLR: begin
          if (enh_on) begin
            fifo_trigger_levels <= WDATA;
          end
        end
        // Plain read-write registers, never locked.
        `URSCF_A_LCTL:  line_control          <= WDATA;
        `URSCF_A_GDIR:  gpio_direction        <= WDATA;
        `URSCF_A_GLVL:  gpio_level            <= WDATA;
        `URSCF_A_GIRQ:  gpio_irq_enable       <= WDATA;
        `URSCF_A_IOCTL: io_control            <= WDATA;
        `URSCF_A_XFCTL: extra_feature_control <= WDATA;
        `URSCF_A_EFEAT: enhanced_feature      <= WDATA;
        // Read-only and power-up-only indexes are ignored here.
        default: begin
          io_control <= io_control;
        end
      endcase
    end
  end

  // Transmit holding stage; a write while full replaces the waiting byte.
  // A write wins over a take in the same cycle, so the new
  // byte is kept and offered again at the next edge.
  always @(posedge CLOCK) begin
    if (any_rst) begin
      // A byte still waiting at reset is dropped.
      hold_full        <= 1'b0;
      transmit_holding <= `URSCF_RST_ZERO;
    end else if (wr_en && ADDR == `URSCF_A_TXHOLD) begin
      hold_full        <= 1'b1;
      transmit_holding <= WDATA;
    end else if (tx_take) begin
      // The shifter took the byte; the stage is free again.
      hold_full <= 1'b0;
    end
  end

  // Modem change flags: cleared by reset and by a status read.
  // A change in the same cycle as the read wins over the clear.
  // The previous levels trail by one clock, so each change is
  // counted once.
  always @(posedge CLOCK) begin
    if (any_rst) begin
      // The present levels become the reference: no false change.
      modem_change <= 4'h0;
      modem_prev   <= modem_lvl;
    end else begin
      modem_prev <= modem_lvl;
      // A status read clears all but this cycle's changes.
      if (RD && ADDR == `URSCF_A_MSTATE) begin
        modem_change <= modem_lvl ^ modem_prev;
      end else begin
        modem_change <= modem_change | (modem_lvl ^ modem_prev);
      end
    end
  end

  // Read multiplexer; write-only and unmapped indexes read zero.
  // Only the modem status read has a side effect, handled
  // in the modem process.
  always @* begin
    next_rdata = 8'h00;
    case (ADDR)
      `URSCF_A_IENA:    next_rdata = interrupt_enable;
      `URSCF_A_ISRC:    next_rdata = modem_irq ? `URSCF_RST_ZERO : `URSCF_RST_ISRC;
      `URSCF_A_LCTL:    next_rdata = line_control;
      `URSCF_A_MCTL:    next_rdata = modem_control;
      `URSCF_A_LSTATE:  next_rdata = line_state;
      `URSCF_A_MSTATE:  next_rdata = modem_state;
      `URSCF_A_SCRATCH: next_rdata = scratch_pad;
      `URSCF_A_TCR:     next_rdata = flow_halt_resume_levels;
      `URSCF_A_TLR:     next_rdata = fifo_trigger_levels;
      `URSCF_A_TXSPACE: next_rdata = `URSCF_TXSPACE_EMPTY - {7'h00, hold_full};
      // No receiver: the receive fill level stays zero.
      `URSCF_A_RXFILL:  next_rdata = `URSCF_RST_ZERO;
      `URSCF_A_GDIR:    next_rdata = gpio_direction;
      `URSCF_A_GLVL:    next_rdata = gpio_level;
      `URSCF_A_GIRQ:    next_rdata = gpio_irq_enable;
      `URSCF_A_IOCTL:   next_rdata = io_control;
      `URSCF_A_XFCTL:   next_rdata = extra_feature_control;
      `URSCF_A_EFEAT:   next_rdata = enhanced_feature;
      `URSCF_A_DIVLO:   next_rdata = divisor_low_byte;
      `URSCF_A_DIVHI:   next_rdata = divisor_high_byte;
      `URSCF_A_DIVFR:   next_rdata = divisor_fraction;
      `URSCF_A_RES1:    next_rdata = resume_char_one;
      `URSCF_A_RES2:    next_rdata = resume_char_two;
      `URSCF_A_HALT1:   next_rdata = halt_char_one;
      `URSCF_A_HALT2:   next_rdata = halt_char_two;
      default:          next_rdata = 8'h00;
    endcase
  end

  // Read data stand for one cycle after the strobe, zero otherwise.
  // A zero bus outside the answer cycle makes a stray sample
  // easy to see.
  always @(posedge CLOCK) begin
    if (!RST_N || !POR_N) begin
      // A software reset leaves the read data alone.
      RDATA <= 8'h00;
    end else begin
      RDATA <= RD ? next_rdata : 8'h00;
    end
  end

  // Pin outputs: all high during and straight after any reset.
  // TX passes one flop after the shifter, so the line moves a
  // clock after the shifter decides.
  always @(posedge CLOCK) begin
    if (any_rst) begin
      TX    <= 1'b1;
      RTS_N <= 1'b1;
      DTR_N <= 1'b1;
      IRQ_N <= 1'b1;
    end else begin
      // Modem outputs are active low; the interrupt too.
      TX    <= tx_line;
      RTS_N <= !modem_control[`URSCF_MC_RTS];
      DTR_N <= !modem_control[`URSCF_MC_DTR];
      IRQ_N <= !modem_irq;
    end
  end

endmodule

// ==== urscf_bank_assertions.sv ====
// Checker for the channel register bank: reset levels, readback, status.
// Assumes it is bound to urscf_bank and that CLOCK is the only clock.
`timescale 1ns/100ps
module urscf_bank_chk (
  input logic       CLOCK,
  input logic       POR_N,
  input logic       RST_N,
  input logic [4:0] ADDR,
  input logic [7:0] WDATA,
  input logic       WR,
  input logic       RD,
  input logic [7:0] RDATA,
  input logic       CTS_N,
  input logic       DSR_N,
  input logic       RI_N,
  input logic       CD_N,
  input logic       TX,
  input logic       RTS_N,
  input logic       DTR_N,
  input logic       IRQ_N
);
  // Either reset silences every check but the reset-level one.
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N || !POR_N);
  wire [3:0] pins = {CD_N, RI_N, DSR_N, CTS_N};  // Modem inputs in status order.
  // A character register write followed at once by a read of it.
  sequence s_char_wr_rd;
    WR && ADDR >= 5'h16 && ADDR <= 5'h19 ##1 RD && ADDR == $past(ADDR);
  endsequence
  // Modem inputs held long enough to cross the synchroniser.
  sequence s_pins_still;
    $stable(pins) [*8];
  endsequence
  chk_reset_outs_idle: assert property (disable iff (1'b0) (!RST_N || !POR_N) |=>
    TX && RTS_N && DTR_N && IRQ_N && RDATA == 8'h00) else $error("outputs not idle in reset");
  chk_soft_reset_outs: assert property (WR && ADDR == 5'h10 && WDATA[3] |=> ##1
    RTS_N && DTR_N && IRQ_N) else $error("software reset left an output active");
  chk_char_readback: assert property (s_char_wr_rd |=> RDATA == $past(WDATA, 2))
    else $error("character register readback wrong");
  chk_modem_levels: assert property (s_pins_still ##0 RD && ADDR == 5'h07 |=>
    RDATA[7:4] == ~$past(pins)) else $error("modem status levels not inverted pins");
  chk_rdata_quiet: assert property (!RD |=> RDATA == 8'h00) else $error("read data without a read");
  chk_unmapped_zero: assert property (RD && ADDR > 5'h1a |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  chk_space_range: assert property (RD && ADDR == 5'h0b |=> RDATA == 8'h40 || RDATA == 8'h3f)
    else $error("transmit space out of range");
  chk_modem_out_pins: assert property (WR && ADDR == 5'h05 |=> ##1
    {RTS_N, DTR_N} == ~$past(WDATA[1:0], 2)) else $error("modem outputs not following control");
endmodule
bind urscf_bank urscf_bank_chk u_chk (.CLOCK(CLOCK), .POR_N(POR_N), .RST_N(RST_N), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CTS_N(CTS_N), .DSR_N(DSR_N), .RI_N(RI_N),
  .CD_N(CD_N), .TX(TX), .RTS_N(RTS_N), .DTR_N(DTR_N), .IRQ_N(IRQ_N));

// ==== urscf_consts.vh ====
// Constants for the UART channel register bank: register indexes, reset
// values, field positions and transmit timing counts.
// Assumes inclusion by plain Verilog-2005 design files of this block only.
`ifndef URSCF_CONSTS_VH
`define URSCF_CONSTS_VH

// Register indexes on the five-bit register port.
`define URSCF_A_RXHOLD   5'h00
`define URSCF_A_IENA     5'h01
`define URSCF_A_ISRC     5'h02
`define URSCF_A_FCTL     5'h03
`define URSCF_A_LCTL     5'h04
`define URSCF_A_MCTL     5'h05
`define URSCF_A_LSTATE   5'h06
`define URSCF_A_MSTATE   5'h07
`define URSCF_A_SCRATCH  5'h08
`define URSCF_A_TCR      5'h09
`define URSCF_A_TLR      5'h0a
`define URSCF_A_TXSPACE  5'h0b
`define URSCF_A_RXFILL   5'h0c
`define URSCF_A_GDIR     5'h0d
`define URSCF_A_GLVL     5'h0e
`define URSCF_A_GIRQ     5'h0f
`define URSCF_A_IOCTL    5'h10
`define URSCF_A_XFCTL    5'h11
`define URSCF_A_EFEAT    5'h12
`define URSCF_A_DIVLO    5'h13
`define URSCF_A_DIVHI    5'h14
`define URSCF_A_DIVFR    5'h15
`define URSCF_A_RES1     5'h16
`define URSCF_A_RES2     5'h17
`define URSCF_A_HALT1    5'h18
`define URSCF_A_HALT2    5'h19
`define URSCF_A_TXHOLD   5'h1a

// Reset values.
`define URSCF_RST_DIVLO  8'h01
`define URSCF_RST_DIVHI  8'h00
`define URSCF_RST_SCR    8'hff
`define URSCF_RST_CHAR   8'h00
`define URSCF_RST_ZERO   8'h00
`define URSCF_RST_ISRC   8'h01
`define URSCF_RST_LCTL   8'h1d
`define URSCF_RST_TCR    8'h0f
`define URSCF_TXSPACE_EMPTY 8'h40

// Field positions.
`define URSCF_EF_ENH     4
`define URSCF_EF_ACTS    7
`define URSCF_IO_SRST    3
`define URSCF_XF_TXDIS   2
`define URSCF_MC_DTR     0
`define URSCF_MC_RTS     1
`define URSCF_IE_MODEM   3
`define URSCF_LS_THRE    5
`define URSCF_LS_TEMT    6

// Enhanced-bit masks: bits that only change while the enhanced enable is set.
`define URSCF_MASK_IENA  8'hf0
`define URSCF_MASK_FCTL  8'h30
`define URSCF_MASK_MCTL  8'he0

// Clocks per bit are divisor times the oversampling count.
`define URSCF_SAMP_16    6'd16
`define URSCF_SAMP_8     6'd8
`define URSCF_SAMP_4     6'd4
`define URSCF_FRAME_BITS 4'd10

`endif

// ==== urscf_modem_peer.sv ====
// Far-side modem peer driving the four active-low modem inputs of the bank.
// Assumes the bench sets the wanted levels; each change lands after a lag.
`timescale 1ns/100ps
module urscf_modem_peer (
  input  wire logic [3:0] want,
  input  wire logic [3:0] lag,
  input  wire logic       clk,
  output logic      [3:0] pins
);
  logic [3:0] wait_cnt = 4'h0;  // Cycles a pending change has waited.
  initial pins = 4'hf;          // Idle modem lines sit high.
  // Apply a wish after lag cycles, off the edge as a real pin would move.
  always @(posedge clk) begin
    if (want == pins || wait_cnt == lag) begin
      wait_cnt <= 4'h0;
      pins <= #7 want;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

// ==== urscf_sync.v ====
// Input synchroniser for the four modem input pins.
// Assumes asynchronous pin levels; output rises once stages two and three are both high, and a mismatch drives it low.
`timescale 1ns/100ps
module urscf_sync (
  input  wire       clk,
  input  wire       rst,
  input  wire [3:0] pin,
  output reg  [3:0] level
);

  reg [3:0] stage1;  // First stage, read only by stage two.
  reg [3:0] stage2;  // Second stage.
  reg [3:0] stage3;  // Third stage.

  // Three-flop chain; a high counts once stages two and three are both high, and any mismatch clears the bit.
  // Pins idle high, so the chain resets high.
  always @(posedge clk) begin
    if (rst) begin
      stage1 <= 4'hf;
      stage2 <= 4'hf;
      stage3 <= 4'hf;
      level  <= 4'hf;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= (stage2 & stage3) | (level & ~(stage2 ^ stage3));
    end
  end

endmodule

// ==== urscf_tx.v ====
// Serial transmitter: one start bit, eight data bits, one stop bit.
// Assumes the bank offers a byte only when the holding stage is full.
`timescale 1ns/100ps
`include "urscf_consts.vh"
module urscf_tx (
  input  wire        clk,
  input  wire        rst,
  input  wire [15:0] divisor,
  input  wire [1:0]  samp_sel,
  input  wire        hold_full,
  input  wire [7:0]  hold_data,
  input  wire        pause,
  output reg         take,
  output reg         busy,
  output reg         txd
);

  reg [8:0]  shift;     // Data bits plus the stop bit, sent LSB first.
  reg [3:0]  bit_cnt;   // Bits left in the current frame.
  reg [21:0] tick_cnt;  // Clocks left in the current bit.

  // Clocks per bit from divisor and oversampling; divisor zero acts as one.
  function [21:0] bit_len;
    input [15:0] d;
    input [1:0]  s;
    reg   [5:0]  m;
    begin
      m = s[1] ? `URSCF_SAMP_4 : (s[0] ? `URSCF_SAMP_8 : `URSCF_SAMP_16);
      bit_len = (d == 16'h0000) ? {16'h0000, m} : {6'h00, d} * {16'h0000, m};
    end
  endfunction

  // A frame starts only between characters, so a pause never cuts one.
  always @(posedge clk) begin
    if (rst) begin
      shift    <= 9'h1ff;
      bit_cnt  <= 4'd0;
      tick_cnt <= 22'd0;
      take     <= 1'b0;
      busy     <= 1'b0;
      txd      <= 1'b1;
    end else begin
      take <= 1'b0;
      if (busy) begin
        if (tick_cnt > 22'd1) begin
          tick_cnt <= tick_cnt - 22'd1;
        end else if (bit_cnt > 4'd1) begin
          txd      <= shift[0];
          shift    <= {1'b1, shift[8:1]};
          bit_cnt  <= bit_cnt - 4'd1;
          tick_cnt <= bit_len(divisor, samp_sel);
        end else begin
          busy <= 1'b0;  // Stop bit done; line stays high.
        end
      end else if (hold_full && !take && !pause) begin
        txd      <= 1'b0;
        shift    <= {1'b1, hold_data};
        bit_cnt  <= `URSCF_FRAME_BITS;
        tick_cnt <= bit_len(divisor, samp_sel);
        take     <= 1'b1;
        busy     <= 1'b1;
      end
    end
  end

endmodule
